// ===== rtl/uart_lin_pkg.sv
// constants and types shared by the serial port with break support
package uart_lin_pkg;
   localparam int DATA_BITS = 8;
   localparam int DIV_W = 8;
   // register offsets on the plain register port
   localparam logic [2:0] ADDR_MODE = 3'h0;
   localparam logic [2:0] ADDR_ERR = 3'h1;
   localparam logic [2:0] ADDR_RXBUF = 3'h2;
   localparam logic [2:0] ADDR_TXBUF = 3'h3;
   localparam logic [2:0] ADDR_TXSTAT = 3'h4;
   localparam logic [2:0] ADDR_CLKSEL = 3'h5;
   localparam logic [2:0] ADDR_DIV = 3'h6;
   localparam logic [2:0] ADDR_RXCTL = 3'h7;
   // field positions
   localparam int BIT_FLAG = 7;
   localparam int BIT_ARM = 6;
   localparam int ERR_OVR = 0;
   localparam int ERR_PAR = 1;
   localparam int ERR_FRM = 2;
   localparam int TXS_BUSY = 0;
   localparam int TXS_FULL = 1;
   // reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] RXBUF_RESET = 8'hff;
   localparam logic [7:0] DIV_RESET = 8'hff;
   localparam logic [3:0] CLKSEL_RESET = 4'h0;
   // bit counts, bit indices and the minimum divisor
   localparam logic [3:0] BREAK_MIN_BITS = 4'hb;
   localparam logic [3:0] LOW_CNT_MAX = 4'hf;
   localparam logic [3:0] LOW_CNT_START = 4'h1;
   localparam logic [3:0] TX_BITS_NOPAR = 4'ha;
   localparam logic [3:0] TX_BITS_PAR = 4'hb;
   localparam logic [3:0] RX_DATA_LAST = 4'h7;
   localparam logic [3:0] RX_PAR_IDX = 4'h8;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [7:0] DIV_MIN = 8'h08;

   typedef enum logic [1:0] {par_none, par_zero, par_odd, par_even} parity_e;

   typedef struct packed {
      logic power;
      logic txe;
      logic rxe;
      parity_e parity;
      logic [2:0] spare;
   } mode_s;
endpackage : uart_lin_pkg

// ===== rtl/baud_counter.sv
// one 8-bit baud divider counter, giving a pulse every divisor base ticks
`timescale 1ns/10ps
`default_nettype none
module baud_counter #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // control
   input wire logic tick,
   input wire logic run,
   input wire logic clear,
   input wire logic [W-1:0] divisor,
   // result
   output logic [W-1:0] count,
   output logic half_done
);
   logic [W-1:0] next_count;
   logic at_end;

   if (W < 4) begin : g_check
      $error("baud_counter: width too small");
   end

   // half_done ignores clear so the frame logic can use it to clear without a loop
   assign at_end = (count == (divisor - {{(W-1){1'b0}}, 1'b1}));
   assign half_done = run && tick && at_end;

   always_comb begin
      next_count = count;
      if (!run || clear) begin
         next_count = '0;
      end else if (tick) begin
         next_count = at_end ? '0 : count + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count <= '0;
      end else if (clk_en) begin
         count <= next_count;
      end
   end
endmodule : baud_counter
`default_nettype wire

// ===== rtl/uart_lin_break_and_baud_gen.sv
// serial port core: rx filter, break receive, baud generator, registers
`timescale 1ns/10ps
`default_nettype none
module uart_lin_break_and_baud_gen #(
   parameter int PRESCALE_W = 16
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // serial pins
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   // completion events
   output logic tx_done_irq,
   output logic rx_done_irq
);
   if (PRESCALE_W < 16) begin : g_check
      $error("prescaler must cover all sixteen clock selections");
   end

   typedef enum {tx_idle, tx_busy} tx_state_e;
   typedef enum {rx_idle, rx_start, rx_data} rx_state_e;

   // control registers
   uart_lin_pkg::mode_s mode, next_mode;
   logic [3:0] clk_sel, next_clk_sel;
   logic [7:0] baud_divisor, next_baud_divisor;
   logic [7:0] next_rdata;
   // base clock and filter
   logic [PRESCALE_W-1:0] pre_cnt, next_pre_cnt, pre_mask;
   logic base_tick;
   logic rx_sync1, rx_sync2, samp_a, samp_b, rx_lvl, rx_lvl_d;
   logic next_samp_a, next_samp_b, next_rx_lvl, next_rx_lvl_d;
   // transmitter
   tx_state_e tx_state, next_tx_state;
   logic [10:0] tx_frame, next_tx_frame;
   logic [3:0] tx_left, next_tx_left;
   logic tx_phase, next_tx_phase, tx_full, next_tx_full;
   logic [7:0] tx_buf, next_tx_buf;
   logic next_tx_line, next_tx_irq, tx_run, tx_clear, tx_half, wr_tx;
   // receiver
   rx_state_e rx_state, next_rx_state;
   logic [7:0] rx_shift, next_rx_shift, rx_buf, next_rx_buf;
   logic [3:0] rx_idx, next_rx_idx, low_cnt, next_low_cnt;
   logic rx_phase, next_rx_phase, rx_par, next_rx_par, rx_full, next_rx_full;
   logic brk, next_brk, arm, next_arm, flag, next_flag, next_rx_irq;
   logic [2:0] err, next_err;
   logic rx_run, rx_half, rx_center, rd_buf, rd_err, par_bad;

   function automatic logic [10:0] build_frame(input logic [7:0] d,
                                               input uart_lin_pkg::parity_e p);
      logic pbit;
      pbit = 1'b1;
      case (p)
         uart_lin_pkg::par_zero: pbit = 1'b0;
         uart_lin_pkg::par_odd: pbit = ~^d;
         uart_lin_pkg::par_even: pbit = ^d;
         default: pbit = 1'b1;
      endcase
      build_frame = {1'b1, pbit, d, 1'b0};
   endfunction : build_frame

   // base clock: power gates the prescaled tick, so nothing moves while off
   assign pre_mask = PRESCALE_W'((1 << clk_sel) - 1);
   assign base_tick = mode.power && ((pre_cnt & pre_mask) == pre_mask);
   assign next_pre_cnt = mode.power ? pre_cnt + PRESCALE_W'(1) : '0;

   // noise filter: the match detector adds three base clocks of lag
   always_comb begin
      next_samp_a = samp_a;
      next_samp_b = samp_b;
      next_rx_lvl = rx_lvl;
      next_rx_lvl_d = rx_lvl_d;
      if (!mode.power) begin
         next_samp_a = 1'b1;
         next_samp_b = 1'b1;
         next_rx_lvl = 1'b1;
         next_rx_lvl_d = 1'b1;
      end else if (base_tick) begin
         next_samp_a = rx_sync2;
         next_samp_b = samp_a;
         next_rx_lvl_d = rx_lvl;
         if (samp_a == samp_b) begin
            next_rx_lvl = samp_b;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rx_sync1 <= 1'b1;
         rx_sync2 <= 1'b1;
         samp_a <= 1'b1;
         samp_b <= 1'b1;
         rx_lvl <= 1'b1;
         rx_lvl_d <= 1'b1;
         pre_cnt <= '0;
      end else if (clk_en) begin
         rx_sync1 <= serial_rx_pin;
         rx_sync2 <= rx_sync1;
         samp_a <= next_samp_a;
         samp_b <= next_samp_b;
         rx_lvl <= next_rx_lvl;
         rx_lvl_d <= next_rx_lvl_d;
         pre_cnt <= next_pre_cnt;
      end
   end

   // two independent dividers
   baud_counter #(.W(uart_lin_pkg::DIV_W)) u_tx_cnt (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tick(base_tick),
      .run(tx_run),
      .clear(tx_clear),
      .divisor(baud_divisor),
      .count(),
      .half_done(tx_half)
   );

   baud_counter #(.W(uart_lin_pkg::DIV_W)) u_rx_cnt (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tick(base_tick),
      .run(rx_run && rx_state != rx_idle),
      .clear(1'b0),
      .divisor(baud_divisor),
      .count(),
      .half_done(rx_half)
   );

   // control registers and read port
   always_comb begin
      next_mode = mode;
      next_clk_sel = clk_sel;
      next_baud_divisor = baud_divisor;
      next_rdata = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            uart_lin_pkg::ADDR_MODE: next_mode = uart_lin_pkg::mode_s'(reg_wdata);
            uart_lin_pkg::ADDR_CLKSEL: next_clk_sel = reg_wdata[3:0];
            uart_lin_pkg::ADDR_DIV: next_baud_divisor = reg_wdata;
            default: next_mode = mode;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            uart_lin_pkg::ADDR_MODE: next_rdata = mode;
            uart_lin_pkg::ADDR_ERR: next_rdata = {5'h00, err};
            uart_lin_pkg::ADDR_RXBUF: next_rdata = rx_buf;
            uart_lin_pkg::ADDR_TXSTAT: next_rdata = {6'h00, tx_full, tx_state == tx_busy};
            uart_lin_pkg::ADDR_CLKSEL: next_rdata = {4'h0, clk_sel};
            uart_lin_pkg::ADDR_DIV: next_rdata = baud_divisor;
            uart_lin_pkg::ADDR_RXCTL: next_rdata = {flag, arm, 6'h00};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mode <= uart_lin_pkg::mode_s'(uart_lin_pkg::MODE_RESET);
         clk_sel <= uart_lin_pkg::CLKSEL_RESET;
         baud_divisor <= uart_lin_pkg::DIV_RESET;
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         mode <= next_mode;
         clk_sel <= next_clk_sel;
         baud_divisor <= next_baud_divisor;
         reg_rdata <= next_rdata;
      end
   end

   // transmitter: one frame in shift, one byte waiting
   assign tx_run = mode.power && mode.txe;
   assign wr_tx = reg_wr && reg_addr == uart_lin_pkg::ADDR_TXBUF;
   assign tx_clear = tx_run && ((tx_state == tx_idle && wr_tx)
                     || (tx_state == tx_busy && tx_half && tx_phase
                         && tx_left == uart_lin_pkg::CNT_ONE && tx_full));

   always_comb begin
      next_tx_state = tx_state;
      next_tx_frame = tx_frame;
      next_tx_left = tx_left;
      next_tx_phase = tx_phase;
      next_tx_full = tx_full;
      next_tx_buf = tx_buf;
      next_tx_irq = 1'b0;
      if (!tx_run) begin
         next_tx_state = tx_idle;
         next_tx_full = 1'b0;
         next_tx_phase = 1'b0;
      end else begin
         case (tx_state)
            tx_idle: begin
               if (wr_tx) begin
                  next_tx_frame = build_frame(reg_wdata, mode.parity);
                  next_tx_left = (mode.parity == uart_lin_pkg::par_none) ?
                                 uart_lin_pkg::TX_BITS_NOPAR : uart_lin_pkg::TX_BITS_PAR;
                  next_tx_phase = 1'b0;
                  next_tx_state = tx_busy;
               end
            end
            tx_busy: begin
               if (wr_tx) begin
                  next_tx_buf = reg_wdata;
                  next_tx_full = 1'b1;
               end
               if (tx_half) begin
                  next_tx_phase = !tx_phase;
                  if (tx_phase) begin
                     if (tx_left == uart_lin_pkg::CNT_ONE) begin
                        next_tx_irq = 1'b1;
                        // without a waiting byte the counter runs on uncleared
                        if (tx_full) begin
                           next_tx_frame = build_frame(tx_buf, mode.parity);
                           next_tx_left = (mode.parity == uart_lin_pkg::par_none) ?
                                          uart_lin_pkg::TX_BITS_NOPAR :
                                          uart_lin_pkg::TX_BITS_PAR;
                           next_tx_full = 1'b0;
                        end else begin
                           next_tx_state = tx_idle;
                        end
                     end else begin
                        next_tx_frame = {1'b1, tx_frame[10:1]};
                        next_tx_left = tx_left - uart_lin_pkg::CNT_ONE;
                     end
                  end
               end
            end
            default: next_tx_state = tx_idle;
         endcase
      end
      next_tx_line = (next_tx_state == tx_busy) ? next_tx_frame[0] : 1'b1;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         tx_state <= tx_idle;
         tx_frame <= '1;
         tx_left <= 4'h0;
         tx_phase <= 1'b0;
         tx_full <= 1'b0;
         tx_buf <= 8'h00;
         serial_tx_pin <= 1'b1;
         tx_done_irq <= 1'b0;
      end else if (clk_en) begin
         tx_state <= next_tx_state;
         tx_frame <= next_tx_frame;
         tx_left <= next_tx_left;
         tx_phase <= next_tx_phase;
         tx_full <= next_tx_full;
         tx_buf <= next_tx_buf;
         serial_tx_pin <= next_tx_line;
         tx_done_irq <= next_tx_irq;
      end
   end

   // receiver, including armed break reception
   assign rx_run = mode.power && mode.rxe;
   assign rx_center = rx_half && rx_phase;
   assign rd_buf = reg_rd && reg_addr == uart_lin_pkg::ADDR_RXBUF;
   assign rd_err = reg_rd && reg_addr == uart_lin_pkg::ADDR_ERR;
   assign par_bad = (mode.parity == uart_lin_pkg::par_odd) ? !(^{rx_shift, rx_par}) :
                    (mode.parity == uart_lin_pkg::par_even) ? ^{rx_shift, rx_par} : 1'b0;

   always_comb begin
      next_rx_state = rx_state;
      next_rx_shift = rx_shift;
      next_rx_idx = rx_idx;
      next_rx_phase = rx_phase;
      next_rx_par = rx_par;
      next_low_cnt = low_cnt;
      next_brk = brk;
      next_rx_irq = 1'b0;
      next_rx_buf = rx_buf;
      next_rx_full = rd_buf ? 1'b0 : rx_full;
      next_err = rd_err ? 3'h0 : err;
      next_arm = arm;
      next_flag = flag;
      if (reg_wr && reg_addr == uart_lin_pkg::ADDR_RXCTL) begin
         next_arm = reg_wdata[uart_lin_pkg::BIT_ARM];
      end
      if (!mode.power) begin
         // power off is the functional reset of the receive side
         next_rx_state = rx_idle;
         next_rx_buf = uart_lin_pkg::RXBUF_RESET;
         next_rx_full = 1'b0;
         next_err = 3'h0;
         next_arm = 1'b0;
         next_flag = 1'b0;
      end else if (!rx_run) begin
         next_rx_state = rx_idle;
      end else begin
         case (rx_state)
            rx_idle: begin
               if (rx_lvl_d && !rx_lvl) begin
                  next_rx_state = rx_start;
               end
            end
            rx_start: begin
               if (rx_half) begin
                  if (!rx_lvl) begin
                     next_rx_state = rx_data;
                     next_rx_phase = 1'b0;
                     next_rx_idx = 4'h0;
                     next_brk = arm;
                     next_low_cnt = uart_lin_pkg::LOW_CNT_START;
                     if (arm) begin
                        next_flag = 1'b1;
                     end
                  end else begin
                     next_rx_state = rx_idle;
                  end
               end
            end
            rx_data: begin
               if (rx_half) begin
                  next_rx_phase = !rx_phase;
               end
               if (rx_center && brk) begin
                  if (!rx_lvl) begin
                     if (low_cnt != uart_lin_pkg::LOW_CNT_MAX) begin
                        next_low_cnt = low_cnt + uart_lin_pkg::CNT_ONE;
                     end
                  end else begin
                     // high sample ends the break; no errors, no buffer load
                     next_rx_state = rx_idle;
                     if (low_cnt >= uart_lin_pkg::BREAK_MIN_BITS) begin
                        next_rx_irq = 1'b1;
                        next_arm = 1'b0;
                        next_flag = 1'b0;
                     end
                  end
               end else if (rx_center) begin
                  next_rx_idx = rx_idx + uart_lin_pkg::CNT_ONE;
                  if (rx_idx <= uart_lin_pkg::RX_DATA_LAST) begin
                     next_rx_shift = {rx_lvl, rx_shift[7:1]};
                  end else if (rx_idx == uart_lin_pkg::RX_PAR_IDX
                               && mode.parity != uart_lin_pkg::par_none) begin
                     next_rx_par = rx_lvl;
                  end else begin
                     next_rx_state = rx_idle;
                     next_rx_irq = 1'b1;
                     next_err[uart_lin_pkg::ERR_FRM] = next_err[uart_lin_pkg::ERR_FRM] | !rx_lvl;
                     next_err[uart_lin_pkg::ERR_PAR] = next_err[uart_lin_pkg::ERR_PAR] | par_bad;
                     if (rx_full && !rd_buf) begin
                        next_err[uart_lin_pkg::ERR_OVR] = 1'b1;
                     end else begin
                        next_rx_buf = rx_shift;
                        next_rx_full = 1'b1;
                     end
                  end
               end
            end
            default: next_rx_state = rx_idle;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rx_state <= rx_idle;
         rx_shift <= 8'h00;
         rx_idx <= 4'h0;
         rx_phase <= 1'b0;
         rx_par <= 1'b0;
         low_cnt <= 4'h0;
         brk <= 1'b0;
         rx_buf <= uart_lin_pkg::RXBUF_RESET;
         rx_full <= 1'b0;
         err <= 3'h0;
         arm <= 1'b0;
         flag <= 1'b0;
         rx_done_irq <= 1'b0;
      end else if (clk_en) begin
         rx_state <= next_rx_state;
         rx_shift <= next_rx_shift;
         rx_idx <= next_rx_idx;
         rx_phase <= next_rx_phase;
         rx_par <= next_rx_par;
         low_cnt <= next_low_cnt;
         brk <= next_brk;
         rx_buf <= next_rx_buf;
         rx_full <= next_rx_full;
         err <= next_err;
         arm <= next_arm;
         flag <= next_flag;
         rx_done_irq <= next_rx_irq;
      end
   end
endmodule : uart_lin_break_and_baud_gen
`default_nettype wire

// ===== sim/uart_lin_chk.sv
// concurrent checks on the serial port core pins
`timescale 1ns/10ps
`default_nettype none
module uart_lin_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // serial pins and events
   input wire logic serial_rx_pin,
   input wire logic serial_tx_pin,
   input wire logic tx_done_irq,
   input wire logic rx_done_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n || !clk_en);
   a_div_readback: assert property (reg_wr && reg_addr == uart_lin_pkg::ADDR_DIV
      ##2 reg_rd && reg_addr == uart_lin_pkg::ADDR_DIV |=> reg_rdata == $past(reg_wdata, 3))
      else $error("divisor reads back wrong");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_tx_low_min: assert property ($fell(serial_tx_pin) |-> (!serial_tx_pin) [*8])
      else $error("low tx bit too short");
   a_tx_high_min: assert property ($rose(serial_tx_pin) |-> serial_tx_pin [*8])
      else $error("high tx bit too short");
   a_txirq_pulse: assert property (tx_done_irq |=> !tx_done_irq)
      else $error("tx done longer than one cycle");
   // a back-to-back start bit begins with the pulse, so look at the stop just before it
   a_txirq_stop: assert property (tx_done_irq |-> $past(serial_tx_pin)
      && $past(serial_tx_pin, 8))
      else $error("tx done without stop level");
   a_rxirq_pulse: assert property (rx_done_irq |=> !rx_done_irq)
      else $error("rx done longer than one cycle");
   a_rxirq_line: assert property (rx_done_irq |-> $past(serial_rx_pin, 4))
      else $error("rx done while line low");
   c_tx_done: cover property (tx_done_irq);
   c_rx_done: cover property (rx_done_irq);
   c_div_rd: cover property (reg_rd && reg_addr == uart_lin_pkg::ADDR_DIV);
endmodule : uart_lin_chk
bind uart_lin_break_and_baud_gen uart_lin_chk uart_lin_chk_inst (.core_clk, .reset_n,
   .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_rx_pin,
   .serial_tx_pin, .tx_done_irq, .rx_done_irq);
`default_nettype wire

// ===== sim/lin_peer.sv
// peer serial node driving the port's receive line
`timescale 1ns/10ps
`default_nettype none
module lin_peer (
   // clock
   input wire logic core_clk,
   // receive line of the port, idle high
   output logic line
);
   initial begin
      line = 1'b1;
   end
   // lows above zero sends a break; returns as the stop level begins
   task automatic send(input logic [7:0] d, input int lows, input int bt);
      logic [8:0] f;
      f = {d, 1'b0};
      @(posedge core_clk);
      for (int i = 0; i < (lows > 0 ? lows : 9); i++) begin
         line <= lows > 0 ? 1'b0 : f[i];
         repeat (bt) @(posedge core_clk);
      end
      line <= 1'b1;
   endtask : send
   // single-cycle low spike, only when a test asks for it
   task automatic glitch();
      @(posedge core_clk);
      line <= 1'b0;
      @(posedge core_clk);
      line <= 1'b1;
   endtask : glitch
endmodule : lin_peer
`default_nettype wire

// ===== sim/uart_lin_break_and_baud_gen_tb.sv
// self-checking bench for the serial port core
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
   total_checks++; \
   if ((a) !== (e)) begin \
      failures++; \
      $display("BAD %0t got %h want %h", $time, a, e); \
   end end
module uart_lin_break_and_baud_gen_tb;
   logic core_clk, reset_n, reg_wr, reg_rd, rx_line, tx_pin, tx_irq, rx_irq;
   logic clk_en;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [7:0] rx_bytes [2] = '{8'ha5, 8'h3c};
   int failures = 0;
   int total_checks = 0;
   uart_lin_break_and_baud_gen uart_lin_break_and_baud_gen_inst (.core_clk, .reset_n,
      .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .serial_rx_pin(rx_line), .serial_tx_pin(tx_pin), .tx_done_irq(tx_irq),
      .rx_done_irq(rx_irq));
   lin_peer lin_peer_inst (.core_clk, .line(rx_line));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd
   // a missing event ends the run at once, no point waiting on a dead port
   task automatic wait_irq(input logic rx, input int n, input logic want);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < n && !seen; i++) begin
         @(posedge core_clk);
         #1;
         seen = rx ? rx_irq : tx_irq;
      end
      `CHK(seen, want)
      if (want && !seen) begin
         test_done();
      end
   endtask : wait_irq
   // checks each bit in its middle, so tick alignment slack is tolerated
   task automatic tx_frame(input logic [7:0] m, input logic [7:0] d, input int bt);
      logic [10:0] f;
      f = {1'b1, m[4] & ^d, d, 1'b0};
      wr(3'h0, m);
      wr(3'h3, d);
      for (int i = 0; i < 11; i++) begin
         repeat (i == 0 ? bt / 2 : bt) @(posedge core_clk);
         #1;
         `CHK(tx_pin, f[i])
      end
      wait_irq(1'b0, bt, 1'b1);
   endtask : tx_frame
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(3'h6, 8'hff);
      rd(3'h2, 8'hff);
      rd(3'h7, 8'h00);
      wr(3'h6, 8'h08);
      rd(3'h6, 8'h08);
      // a frozen core must ignore the strobe
      clk_en <= 1'b0;
      wr(3'h6, 8'h55);
      clk_en <= 1'b1;
      rd(3'h6, 8'h08);
      wr(3'h0, 8'h80);
      wr(3'h3, 8'h00);
      repeat (20) @(posedge core_clk);
      `CHK(tx_pin, 1'b1)
      tx_frame(8'hc8, 8'h00, 16);
      wr(3'h5, 8'h01);
      tx_frame(8'hd8, 8'h4a, 32);
      wr(3'h5, 8'h00);
      // back-to-back pair with odd parity: the second start follows the first stop
      wr(3'h0, 8'hd0);
      wr(3'h3, 8'h55);
      wr(3'h3, 8'haa);
      rd(3'h4, 8'h03);
      wait_irq(1'b0, 190, 1'b1);
      `CHK(tx_pin, 1'b0)
      rd(3'h4, 8'h01);
      wait_irq(1'b0, 190, 1'b1);
      `CHK(tx_pin, 1'b1)
      rd(3'h4, 8'h00);
      wr(3'h0, 8'ha0);
      wr(3'h7, 8'h40);
      fork
         lin_peer_inst.send(8'h00, 11, 16);
         begin
            repeat (80) @(posedge core_clk);
            rd(3'h7, 8'hc0);
         end
      join
      wait_irq(1'b1, 40, 1'b1);
      rd(3'h7, 8'h00);
      rd(3'h1, 8'h00);
      rd(3'h2, 8'hff);
      wr(3'h7, 8'h40);
      lin_peer_inst.send(8'h00, 10, 16);
      wait_irq(1'b1, 40, 1'b0);
      rd(3'h7, 8'hc0);
      wr(3'h0, 8'h00);
      rd(3'h7, 8'h00);
      wr(3'h0, 8'ha0);
      lin_peer_inst.glitch();
      wait_irq(1'b1, 300, 1'b0);
      for (int i = 0; i < 2; i++) begin
         lin_peer_inst.send(rx_bytes[i], 0, 16);
         wait_irq(1'b1, 40, 1'b1);
         rd(3'h2, rx_bytes[i]);
      end
      rd(3'h1, 8'h00);
      wr(3'h0, 8'h80);
      lin_peer_inst.send(8'h11, 0, 16);
      wait_irq(1'b1, 40, 1'b0);
      rd(3'h2, 8'h3c);
      test_done();
   end
endmodule : uart_lin_break_and_baud_gen_tb
`default_nettype wire
